/* File: fifo_sync_pkg.sv */
// constants, types and register map of the packet buffer with pattern detector
`default_nettype none
package fifo_sync_pkg;
  localparam int DEPTH = 64;
  localparam int CNT_W = 7;
  localparam int PTR_W = 6;
  localparam int PAT_W = 64;
  // register byte offsets
  localparam logic [7:0] OFF_FIFO_DATA = 8'h00;
  localparam logic [7:0] OFF_MODE_CTRL = 8'h04;
  localparam logic [7:0] OFF_LEVEL_CONFIG = 8'h08;
  localparam logic [7:0] OFF_PATTERN_CONFIG = 8'h0C;
  localparam logic [7:0] OFF_FIRST_PATTERN = 8'h10;
  localparam logic [7:0] OFF_PATTERN_TAIL = 8'h14;
  localparam logic [7:0] OFF_STATUS = 8'h18;
  // mode_ctrl_reg fields
  localparam int MODE_LSB = 0;
  localparam int PACKET_BIT = 2;
  localparam int BITSYNC_BIT = 3;
  // level_config_reg field
  localparam int TRIP_LSB = 0;
  // pattern_config_reg fields
  localparam int LEN_LSB = 0;
  localparam int DETECT_BIT = 4;
  // status_reg bits
  localparam int ST_VACANT = 0;
  localparam int ST_BRIMMING = 1;
  localparam int ST_LEVEL = 2;
  localparam int ST_OVERFLOW = 3;
  localparam int ST_HIT = 4;
  localparam int ST_TX_DONE = 5;
  localparam int ST_SETTLED = 6;

  typedef enum logic [1:0] {
    MODE_SLEEP = 2'b00,
    MODE_STANDBY = 2'b01,
    MODE_TX = 2'b10,
    MODE_RX = 2'b11
  } mode_t;

  typedef enum logic [1:0] {
    TX_IDLE = 2'b00,
    TX_PATTERN = 2'b01,
    TX_DATA = 2'b10
  } tx_state_t;

  typedef struct packed {
    mode_t mode;
    logic packet_mode;
    logic bitsync_on;
    logic detect_on;
    logic [2:0] len;
    logic [5:0] trip;
  } cfg_t;

  localparam cfg_t CFG_RESET = '{mode: MODE_STANDBY, packet_mode: 1'b1, bitsync_on: 1'b0,
                                 detect_on: 1'b0, len: 3'h3, trip: 6'h0F};
  localparam logic [63:0] PATTERN_RESET = 64'h0101_0101_0101_0101;
endpackage
`default_nettype wire

/* File: packet_fifo_sync_detect.sv */
// packet buffer, serial shift register and pattern detector behind an apb slave
//
// Design decisions made here: the APB slave port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - buffer is 64 entries of one byte, whole bytes only.
// - transmit shifts buffer bytes out msb first at bit rate.
// - receive collects bits and writes each full byte to the buffer.
// - buffer_vacant high exactly when buffer holds no bytes.
// - on a host read buffer_vacant updates at the start of the read.
// - buffer_brimming high exactly when all 64 locations are occupied.
// - write into a full buffer drops the byte; sets overflow_sticky except a host write in sleep or receive.
// - writing one to overflow_sticky clears it and empties the buffer.
// - frame_tx_done rises once the last shifted bit has been sent.
// - level_flag is recomputed only on a buffer read, write or clear.
// - after full, level_flag is frozen until the buffer is empty again.
// - buffer kept across sleep/standby, idle into transmit, and receive to idle.
// - buffer emptied entering receive from idle, receive to transmit, leaving transmit.
// - detection runs only when enabled and packet mode or bit sync on.
// - received bits shift through and are compared, match sets pattern_hit.
// - first received bit meets pattern bit 63, last meets lsb of last byte.
// - pattern_hit clears on leaving receive or on a buffer clear.
// - pattern_length picks 1 to 8 bytes, also used when sending.
// - 64-bit pattern_bytes, inserted ahead of data in packet transmit with detection enabled.
module packet_fifo_sync_detect #(
  parameter int ADDR_W = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic bit_clk,
  input wire logic rx_bit,
  output logic tx_bit,
  output logic buffer_vacant,
  output logic buffer_brimming,
  output logic level_flag,
  output logic overflow_sticky,
  output logic pattern_hit,
  output logic frame_tx_done,
  output logic mode_settled
);
  localparam int DEPTH = fifo_sync_pkg::DEPTH;

  // ---------------- apb slave and configuration
  fifo_sync_pkg::cfg_t cfg_ff, nxt_cfg;
  logic [63:0] pattern_ff, nxt_pattern;
  logic [31:0] prdata_ff, nxt_prdata;
  logic pready_ff, nxt_pready;
  logic pslverr_ff, nxt_pslverr;
  logic [7:0] mem [DEPTH];
  logic [fifo_sync_pkg::PTR_W-1:0] wptr_ff, rptr_ff, nxt_wptr, nxt_rptr;
  logic [fifo_sync_pkg::CNT_W-1:0] count_ff, nxt_count;
  logic vacant_ff, brim_ff, level_ff, hold_ff, ovf_ff, hit_ff, done_ff, settled_ff;
  fifo_sync_pkg::mode_t mode_ff, nxt_mode;
  logic setup, wr_acc, rd_setup, hit_addr, mapped;
  logic [7:0] addr;
  logic host_push, host_pop, sr_push, sr_pop;
  logic [7:0] sr_push_data;
  logic mode_clear;

  assign addr = 8'(paddr);
  assign setup = psel & ~penable;
  // write takes effect at the edge where the access phase meets pready
  assign wr_acc = psel & penable & pready_ff & pwrite;
  assign rd_setup = setup & ~pwrite;

  always_comb begin
    mapped = 1'b1;
    nxt_prdata = 32'h0000_0000;
    case (addr)
      fifo_sync_pkg::OFF_FIFO_DATA: nxt_prdata[7:0] = (count_ff != '0) ? mem[rptr_ff] : 8'h00;
      fifo_sync_pkg::OFF_MODE_CTRL: begin
        nxt_prdata[fifo_sync_pkg::MODE_LSB +: 2] = cfg_ff.mode;
        nxt_prdata[fifo_sync_pkg::PACKET_BIT] = cfg_ff.packet_mode;
        nxt_prdata[fifo_sync_pkg::BITSYNC_BIT] = cfg_ff.bitsync_on;
      end
      fifo_sync_pkg::OFF_LEVEL_CONFIG: nxt_prdata[fifo_sync_pkg::TRIP_LSB +: 6] = cfg_ff.trip;
      fifo_sync_pkg::OFF_PATTERN_CONFIG: begin
        nxt_prdata[fifo_sync_pkg::LEN_LSB +: 3] = cfg_ff.len;
        nxt_prdata[fifo_sync_pkg::DETECT_BIT] = cfg_ff.detect_on;
      end
      fifo_sync_pkg::OFF_FIRST_PATTERN: nxt_prdata = pattern_ff[63:32];
      fifo_sync_pkg::OFF_PATTERN_TAIL: nxt_prdata = pattern_ff[31:0];
      fifo_sync_pkg::OFF_STATUS: begin
        nxt_prdata[fifo_sync_pkg::ST_VACANT] = vacant_ff;
        nxt_prdata[fifo_sync_pkg::ST_BRIMMING] = brim_ff;
        nxt_prdata[fifo_sync_pkg::ST_LEVEL] = level_ff;
        nxt_prdata[fifo_sync_pkg::ST_OVERFLOW] = ovf_ff;
        nxt_prdata[fifo_sync_pkg::ST_HIT] = hit_ff;
        nxt_prdata[fifo_sync_pkg::ST_TX_DONE] = done_ff;
        nxt_prdata[fifo_sync_pkg::ST_SETTLED] = settled_ff;
      end
      default: mapped = 1'b0;
    endcase
    if (!setup || pwrite) begin
      nxt_prdata = prdata_ff;
    end
    nxt_pready = setup;
    nxt_pslverr = setup & ~mapped;
    nxt_cfg = cfg_ff;
    nxt_pattern = pattern_ff;
    if (wr_acc) begin
      case (addr)
        fifo_sync_pkg::OFF_MODE_CTRL: begin
          nxt_cfg.mode = fifo_sync_pkg::mode_t'(pwdata[fifo_sync_pkg::MODE_LSB +: 2]);
          nxt_cfg.packet_mode = pwdata[fifo_sync_pkg::PACKET_BIT];
          nxt_cfg.bitsync_on = pwdata[fifo_sync_pkg::BITSYNC_BIT];
        end
        fifo_sync_pkg::OFF_LEVEL_CONFIG: nxt_cfg.trip = pwdata[fifo_sync_pkg::TRIP_LSB +: 6];
        fifo_sync_pkg::OFF_PATTERN_CONFIG: begin
          nxt_cfg.len = pwdata[fifo_sync_pkg::LEN_LSB +: 3];
          nxt_cfg.detect_on = pwdata[fifo_sync_pkg::DETECT_BIT];
        end
        fifo_sync_pkg::OFF_FIRST_PATTERN: nxt_pattern[63:32] = pwdata;
        fifo_sync_pkg::OFF_PATTERN_TAIL: nxt_pattern[31:0] = pwdata;
        default: nxt_pattern = pattern_ff;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_ff <= fifo_sync_pkg::CFG_RESET;
      pattern_ff <= fifo_sync_pkg::PATTERN_RESET;
      prdata_ff <= 32'h0000_0000;
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
    end else begin
      cfg_ff <= nxt_cfg;
      pattern_ff <= nxt_pattern;
      prdata_ff <= nxt_prdata;
      pready_ff <= nxt_pready;
      pslverr_ff <= nxt_pslverr;
    end
  end

  // ---------------- mode control
  logic [6:0] tx_cnt_ff, nxt_tx_cnt;
  logic sending_ff, nxt_sending;
  logic nxt_settled;

  always_comb begin
    nxt_mode = cfg_ff.mode;
    // leaving transmit waits for the line to finish its last bit
    if (mode_ff == fifo_sync_pkg::MODE_TX && cfg_ff.mode != fifo_sync_pkg::MODE_TX &&
        (tx_cnt_ff != 7'h00 || sending_ff)) begin
      nxt_mode = mode_ff;
    end
    nxt_settled = (nxt_mode == cfg_ff.mode);
    mode_clear = 1'b0;
    if (nxt_mode != mode_ff) begin
      if (mode_ff == fifo_sync_pkg::MODE_TX) begin
        mode_clear = 1'b1;
      end else if (mode_ff == fifo_sync_pkg::MODE_RX) begin
        mode_clear = (nxt_mode == fifo_sync_pkg::MODE_TX);
      end else begin
        mode_clear = (nxt_mode == fifo_sync_pkg::MODE_RX);
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_ff <= fifo_sync_pkg::MODE_STANDBY;
      settled_ff <= 1'b0;
    end else begin
      mode_ff <= nxt_mode;
      settled_ff <= nxt_settled;
    end
  end

  // ---------------- byte buffer and its flags
  logic push, full, do_push, do_pop, ovf_set, ovf_clr, buf_clear, touched;
  logic nxt_vacant, nxt_brim, nxt_level, nxt_hold, nxt_ovf;

  always_comb begin
    full = (count_ff == fifo_sync_pkg::CNT_W'(DEPTH));
    host_push = wr_acc && addr == fifo_sync_pkg::OFF_FIFO_DATA && mode_ff != fifo_sync_pkg::MODE_RX;
    // a read pops at its setup cycle so the vacant flag moves as the read starts
    host_pop = rd_setup && addr == fifo_sync_pkg::OFF_FIFO_DATA && mode_ff != fifo_sync_pkg::MODE_TX &&
               count_ff != '0;
    push = host_push | sr_push;
    do_push = push & ~full;
    do_pop = host_pop | sr_pop;
    ovf_set = (sr_push & full) |
              (host_push & full & (mode_ff == fifo_sync_pkg::MODE_TX || mode_ff == fifo_sync_pkg::MODE_STANDBY));
    ovf_clr = wr_acc && addr == fifo_sync_pkg::OFF_STATUS && pwdata[fifo_sync_pkg::ST_OVERFLOW];
    buf_clear = ovf_clr | mode_clear;
    nxt_ovf = ovf_set | (ovf_ff & ~ovf_clr);
    nxt_wptr = wptr_ff;
    nxt_rptr = rptr_ff;
    nxt_count = count_ff;
    if (buf_clear) begin
      nxt_wptr = '0;
      nxt_rptr = '0;
      nxt_count = '0;
    end else begin
      if (do_push) begin
        nxt_wptr = wptr_ff + 1'b1;
      end
      if (do_pop) begin
        nxt_rptr = rptr_ff + 1'b1;
      end
      nxt_count = count_ff + fifo_sync_pkg::CNT_W'(do_push) - fifo_sync_pkg::CNT_W'(do_pop);
    end
    nxt_vacant = (nxt_count == '0);
    nxt_brim = (nxt_count == fifo_sync_pkg::CNT_W'(DEPTH));
    // level is frozen from full until empty; trip point alone never moves it
    nxt_hold = nxt_brim | (hold_ff & ~nxt_vacant);
    touched = push | do_pop | buf_clear;
    nxt_level = level_ff;
    if (touched && !nxt_hold) begin
      nxt_level = (nxt_count > {1'b0, cfg_ff.trip});
    end
  end

  always_ff @(posedge pclk) begin
    if (do_push && !buf_clear) begin
      mem[wptr_ff] <= host_push ? pwdata[7:0] : sr_push_data;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wptr_ff <= '0;
      rptr_ff <= '0;
      count_ff <= '0;
      vacant_ff <= 1'b1;
      brim_ff <= 1'b0;
      level_ff <= 1'b0;
      hold_ff <= 1'b0;
      ovf_ff <= 1'b0;
    end else begin
      wptr_ff <= nxt_wptr;
      rptr_ff <= nxt_rptr;
      count_ff <= nxt_count;
      vacant_ff <= nxt_vacant;
      brim_ff <= nxt_brim;
      level_ff <= nxt_level;
      hold_ff <= nxt_hold;
      ovf_ff <= nxt_ovf;
    end
  end

  // ---------------- bit clock and receive data synchronisers
  logic bclk_s1_ff, bclk_s2_ff, bclk_s3_ff, rxd_s1_ff, rxd_s2_ff;
  logic bit_edge;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bclk_s1_ff <= 1'b0;
      bclk_s2_ff <= 1'b0;
      bclk_s3_ff <= 1'b0;
      rxd_s1_ff <= 1'b0;
      rxd_s2_ff <= 1'b0;
    end else begin
      bclk_s1_ff <= bit_clk;
      bclk_s2_ff <= bclk_s1_ff;
      bclk_s3_ff <= bclk_s2_ff;
      rxd_s1_ff <= rx_bit;
      rxd_s2_ff <= rxd_s1_ff;
    end
  end

  assign bit_edge = bclk_s2_ff & ~bclk_s3_ff;

  // ---------------- transmit shift register
  fifo_sync_pkg::tx_state_t tx_state_ff, nxt_tx_state;
  logic [63:0] tx_sr_ff, nxt_tx_sr;
  logic tx_bit_ff, nxt_tx_bit, nxt_done, tx_run, done_clr;
  logic [6:0] pat_bits;

  assign pat_bits = {cfg_ff.len + 4'h1, 3'b000};

  always_comb begin
    tx_run = (mode_ff == fifo_sync_pkg::MODE_TX) && (cfg_ff.mode == fifo_sync_pkg::MODE_TX);
    done_clr = wr_acc && addr == fifo_sync_pkg::OFF_STATUS && pwdata[fifo_sync_pkg::ST_TX_DONE];
    nxt_tx_state = tx_state_ff;
    nxt_tx_sr = tx_sr_ff;
    nxt_tx_cnt = tx_cnt_ff;
    nxt_sending = sending_ff;
    nxt_tx_bit = tx_bit_ff;
    nxt_done = done_ff & ~done_clr;
    sr_pop = 1'b0;
    // loads only between bit edges, so a load never races a shift
    case (tx_state_ff)
      fifo_sync_pkg::TX_IDLE: begin
        if (tx_run) begin
          nxt_tx_state = (cfg_ff.packet_mode && cfg_ff.detect_on) ? fifo_sync_pkg::TX_PATTERN :
                         fifo_sync_pkg::TX_DATA;
        end
      end
      fifo_sync_pkg::TX_PATTERN: begin
        if (!tx_run) begin
          nxt_tx_state = fifo_sync_pkg::TX_IDLE;
        end else if (tx_cnt_ff == 7'h00 && !bit_edge) begin
          nxt_tx_sr = pattern_ff;
          nxt_tx_cnt = pat_bits;
          nxt_tx_state = fifo_sync_pkg::TX_DATA;
        end
      end
      fifo_sync_pkg::TX_DATA: begin
        if (!tx_run) begin
          nxt_tx_state = fifo_sync_pkg::TX_IDLE;
        end else if (tx_cnt_ff == 7'h00 && !bit_edge && count_ff != '0) begin
          sr_pop = 1'b1;
          nxt_tx_sr = {mem[rptr_ff], 56'h0};
          nxt_tx_cnt = 7'h08;
        end
      end
      default: nxt_tx_state = fifo_sync_pkg::TX_IDLE;
    endcase
    if (bit_edge && mode_ff == fifo_sync_pkg::MODE_TX) begin
      if (tx_cnt_ff != 7'h00) begin
        nxt_tx_bit = tx_sr_ff[63];
        nxt_tx_sr = {tx_sr_ff[62:0], 1'b0};
        nxt_tx_cnt = tx_cnt_ff - 7'h01;
        nxt_sending = 1'b1;
      end else if (sending_ff) begin
        nxt_sending = 1'b0;
        nxt_tx_bit = 1'b0;
        nxt_done = 1'b1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_state_ff <= fifo_sync_pkg::TX_IDLE;
      tx_sr_ff <= 64'h0;
      tx_cnt_ff <= 7'h00;
      sending_ff <= 1'b0;
      tx_bit_ff <= 1'b0;
      done_ff <= 1'b0;
    end else begin
      tx_state_ff <= nxt_tx_state;
      tx_sr_ff <= nxt_tx_sr;
      tx_cnt_ff <= nxt_tx_cnt;
      sending_ff <= nxt_sending;
      tx_bit_ff <= nxt_tx_bit;
      done_ff <= nxt_done;
    end
  end

  // ---------------- receive shift register and pattern detector
  logic [63:0] hist_ff, nxt_hist, pat_aligned, pat_mask;
  logic [7:0] rx_byte_ff, nxt_rx_byte;
  logic [2:0] rx_bits_ff, nxt_rx_bits;
  logic nxt_hit, detect_run, rx_mode, match, accept;

  always_comb begin
    rx_mode = (mode_ff == fifo_sync_pkg::MODE_RX);
    detect_run = rx_mode && cfg_ff.detect_on && (cfg_ff.packet_mode || cfg_ff.bitsync_on);
    nxt_hist = hist_ff;
    nxt_rx_byte = rx_byte_ff;
    nxt_rx_bits = rx_bits_ff;
    sr_push = 1'b0;
    sr_push_data = 8'h00;
    // newest bit sits at bit 0, so the oldest compared bit meets pattern bit 63
    pat_aligned = pattern_ff >> (7'd64 - pat_bits);
    pat_mask = ~(64'hFFFF_FFFF_FFFF_FFFF << pat_bits);
    match = 1'b0;
    if (bit_edge && detect_run) begin
      nxt_hist = {hist_ff[62:0], rxd_s2_ff};
      match = (((nxt_hist ^ pat_aligned) & pat_mask) == 64'h0);
    end
    // without detection every bit is data; with it, data starts after the hit
    accept = rx_mode && (!detect_run || hit_ff);
    if (!accept) begin
      nxt_rx_bits = 3'h0;
    end else if (bit_edge) begin
      nxt_rx_byte = {rx_byte_ff[6:0], rxd_s2_ff};
      nxt_rx_bits = rx_bits_ff + 3'h1;
      if (rx_bits_ff == 3'h7) begin
        sr_push = 1'b1;
        sr_push_data = {rx_byte_ff[6:0], rxd_s2_ff};
      end
    end
    // a hit in the same cycle as a clear is kept
    nxt_hit = match | (hit_ff & rx_mode & ~buf_clear);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hist_ff <= 64'h0;
      rx_byte_ff <= 8'h00;
      rx_bits_ff <= 3'h0;
      hit_ff <= 1'b0;
    end else begin
      hist_ff <= nxt_hist;
      rx_byte_ff <= nxt_rx_byte;
      rx_bits_ff <= nxt_rx_bits;
      hit_ff <= nxt_hit;
    end
  end

  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign tx_bit = tx_bit_ff;
  assign buffer_vacant = vacant_ff;
  assign buffer_brimming = brim_ff;
  assign level_flag = level_ff;
  assign overflow_sticky = ovf_ff;
  assign pattern_hit = hit_ff;
  assign frame_tx_done = done_ff;
  assign mode_settled = settled_ff;
endmodule
`default_nettype wire

/* File: packet_fifo_checker_sva.sv */
// concurrent assertions on the apb and serial ports of the packet buffer
`timescale 1ns/1ps
`default_nettype none
module packet_fifo_checker #(
  parameter int ADDR_W = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic bit_clk,
  input wire logic rx_bit,
  input wire logic tx_bit,
  input wire logic buffer_vacant,
  input wire logic buffer_brimming,
  input wire logic level_flag,
  input wire logic overflow_sticky,
  input wire logic pattern_hit,
  input wire logic frame_tx_done,
  input wire logic mode_settled
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic wr_acc;
  logic frz_ff;
  logic nxt_frz;
  logic ovf_w1c;
  logic bclk_ff;
  logic nxt_bclk;
  logic [3:0] since_ff;
  logic [3:0] nxt_since;
  logic [2:0] age_ff;
  logic [2:0] nxt_age;
  assign wr_acc = psel && penable && pready && pwrite;
  assign ovf_w1c = wr_acc && paddr == ADDR_W'(fifo_sync_pkg::OFF_STATUS) && pwdata[fifo_sync_pkg::ST_OVERFLOW];
  // both ages saturate so a quiet link or bus never wraps back to a young age
  always_comb begin
    nxt_bclk = bit_clk;
    nxt_since = (bit_clk && !bclk_ff) ? 4'h0 : since_ff + {3'h0, since_ff != 4'hF};
    nxt_age = wr_acc ? 3'h0 : age_ff + {2'h0, age_ff != 3'h7};
    // frozen from the first full cycle until the buffer is seen empty again
    nxt_frz = buffer_brimming || (frz_ff && !buffer_vacant);
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bclk_ff <= 1'b0;
      since_ff <= 4'hF;
      age_ff <= 3'h7;
      frz_ff <= 1'b0;
    end else begin
      bclk_ff <= nxt_bclk;
      since_ff <= nxt_since;
      age_ff <= nxt_age;
      frz_ff <= nxt_frz;
    end
  end
  setup_answer_a: assert property (psel && !penable |=> pready) else $error("no answer after setup");
  answer_pulse_a: assert property (pready |=> !pready) else $error("answer longer than one cycle");
  unmapped_err_a: assert property (psel && !penable && paddr > ADDR_W'(fifo_sync_pkg::OFF_STATUS) |=> pslverr)
    else $error("unmapped access without error");
  flag_excl_a: assert property (!(buffer_vacant && buffer_brimming)) else $error("empty and full together");
  overflow_hold_a: assert property (overflow_sticky && !ovf_w1c |=> overflow_sticky) else $error("overflow lost");
  overflow_clear_a: assert property (ovf_w1c |=> !overflow_sticky && buffer_vacant) else $error("w1c failed");
  trip_quiet_a: assert property (wr_acc && paddr == ADDR_W'(fifo_sync_pkg::OFF_LEVEL_CONFIG) |=> $stable(level_flag))
    else $error("level moved on trip write");
  level_frozen_a: assert property (frz_ff && !buffer_vacant |-> $stable(level_flag))
    else $error("level moved while frozen");
  hit_hold_a: assert property (pattern_hit && age_ff > 3'h3 && !wr_acc |=> pattern_hit) else $error("hit lost");
  done_hold_a: assert property (frame_tx_done && age_ff > 3'h3 && !wr_acc |=> frame_tx_done)
    else $error("done lost");
  tx_on_edge_a: assert property ($changed(tx_bit) |-> since_ff < 4'h7) else $error("tx bit off bit edge");
endmodule
bind packet_fifo_sync_detect packet_fifo_checker #(.ADDR_W(ADDR_W)) packet_fifo_checker_inst (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .bit_clk(bit_clk), .rx_bit(rx_bit),
  .tx_bit(tx_bit), .buffer_vacant(buffer_vacant), .buffer_brimming(buffer_brimming), .level_flag(level_flag),
  .overflow_sticky(overflow_sticky), .pattern_hit(pattern_hit), .frame_tx_done(frame_tx_done),
  .mode_settled(mode_settled));
`default_nettype wire

/* File: modem_model.sv */
// modem side model: bit clock, demodulated bits in, modulated bits captured
`timescale 1ns/1ps
`default_nettype none
module modem_model (
  input wire logic run,
  input wire logic [63:0] rx_word,
  input wire logic tx_bit,
  output logic bit_clk,
  output logic rx_bit,
  output logic [63:0] tx_cap,
  output logic [15:0] edge_cnt
);
  logic [63:0] sh;
  logic idle_lvl;
  // clock stands still between frames; the data line toggles so stale bits never look valid
  initial begin
    bit_clk = 1'b0;
    idle_lvl = 1'b0;
    sh = '0;
    tx_cap = '0;
    edge_cnt = '0;
    #3;
    forever begin
      #80;
      if (run && bit_clk) begin
        sh = {sh[62:0], 1'b0};
        bit_clk = 1'b0;
      end else if (run) begin
        tx_cap = {tx_cap[62:0], tx_bit};
        edge_cnt = edge_cnt + 16'h1;
        bit_clk = 1'b1;
      end else begin
        bit_clk = 1'b0;
        idle_lvl = ~idle_lvl;
        sh = rx_word;
      end
    end
  end
  assign rx_bit = run ? sh[63] : idle_lvl;
endmodule
`default_nettype wire

/* File: tb.sv */
// self-checking bench for the packet buffer with pattern detector
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, bit_clk, rx_bit, tx_bit;
  logic buffer_vacant, buffer_brimming, level_flag, overflow_sticky, pattern_hit, frame_tx_done, mode_settled;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic run, vac_ans, err_ans, found;
  logic [63:0] rx_word, tx_cap;
  logic [15:0] edge_cnt, base;
  int err_count, compares;
  initial pclk = 1'b0;
  always #10 pclk = ~pclk;
  packet_fifo_sync_detect #(.ADDR_W(8)) packet_fifo_sync_detect_inst (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .bit_clk(bit_clk), .rx_bit(rx_bit), .tx_bit(tx_bit),
    .buffer_vacant(buffer_vacant), .buffer_brimming(buffer_brimming), .level_flag(level_flag),
    .overflow_sticky(overflow_sticky), .pattern_hit(pattern_hit), .frame_tx_done(frame_tx_done),
    .mode_settled(mode_settled));
  modem_model modem_model_inst (.run(run), .rx_word(rx_word), .tx_bit(tx_bit), .bit_clk(bit_clk),
    .rx_bit(rx_bit), .tx_cap(tx_cap), .edge_cnt(edge_cnt));
  task conclude();
    $display("compares %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      chk("apb answer", 32'h1, 32'h0);
      conclude();
    end
    rd = prdata;
    err_ans = pslverr;
    vac_ans = buffer_vacant;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task rchk(input logic [7:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0);
    chk("read data", exp, rd);
  endtask
  task settle();
    repeat (3) @(posedge pclk);
  endtask
  task wait_for(input bit done_flag, input int lim);
    int n;
    n = 0;
    settle();
    while ((done_flag ? frame_tx_done : mode_settled) !== 1'b1 && n < lim) begin
      @(posedge pclk);
      n++;
    end
    if (n >= lim) begin
      chk("wait", 32'h1, 32'h0);
      conclude();
    end
  endtask
  initial begin
    presetn = 1'b0;
    {psel, penable, pwrite, run} = 4'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    rx_word = 64'h0;
    err_count = 0;
    compares = 0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    rchk(fifo_sync_pkg::OFF_MODE_CTRL, 32'h5);
    rchk(fifo_sync_pkg::OFF_LEVEL_CONFIG, 32'hF);
    rchk(fifo_sync_pkg::OFF_PATTERN_CONFIG, 32'h3);
    rchk(fifo_sync_pkg::OFF_FIRST_PATTERN, 32'h0101_0101);
    rchk(fifo_sync_pkg::OFF_PATTERN_TAIL, 32'h0101_0101);
    rchk(fifo_sync_pkg::OFF_STATUS, 32'h41);
    rchk(8'h1C, 32'h0);
    chk("unmapped error", 32'h1, {31'h0, err_ans});
    for (int i = 0; i < 64; i++) begin
      xfer(1'b1, fifo_sync_pkg::OFF_FIFO_DATA, 32'(i));
      if (i == 14 || i == 15) begin
        settle();
        chk("level", 32'(i == 15), {31'h0, level_flag});
      end
    end
    settle();
    chk("brimming", 32'h1, {31'h0, buffer_brimming});
    xfer(1'b1, fifo_sync_pkg::OFF_FIFO_DATA, 32'hEE);
    settle();
    chk("overflow", 32'h1, {31'h0, overflow_sticky});
    for (int i = 0; i < 64; i++) begin
      rchk(fifo_sync_pkg::OFF_FIFO_DATA, 32'(i));
      if (i == 53) chk("level frozen", 32'h1, {31'h0, level_flag});
    end
    chk("vacant at answer", 32'h1, {31'h0, vac_ans});
    xfer(1'b1, fifo_sync_pkg::OFF_FIFO_DATA, 32'h12);
    xfer(1'b1, fifo_sync_pkg::OFF_LEVEL_CONFIG, 32'h0);
    settle();
    chk("level on trip", 32'h0, {31'h0, level_flag});
    xfer(1'b1, fifo_sync_pkg::OFF_FIFO_DATA, 32'h34);
    settle();
    chk("level resumed", 32'h1, {31'h0, level_flag});
    xfer(1'b1, fifo_sync_pkg::OFF_STATUS, 32'h8);
    settle();
    chk("overflow clear", 32'h2, {30'h0, buffer_vacant, overflow_sticky});
    xfer(1'b1, fifo_sync_pkg::OFF_FIFO_DATA, 32'h55);
    xfer(1'b1, fifo_sync_pkg::OFF_MODE_CTRL, 32'h4);
    wait_for(1'b0, 200);
    xfer(1'b1, fifo_sync_pkg::OFF_MODE_CTRL, 32'h5);
    wait_for(1'b0, 200);
    chk("kept", 32'h0, {31'h0, buffer_vacant});
    // host keeps every pattern byte nonzero
    xfer(1'b1, fifo_sync_pkg::OFF_FIRST_PATTERN, 32'hA5C3_0101);
    xfer(1'b1, fifo_sync_pkg::OFF_PATTERN_CONFIG, 32'h11);
    rx_word = 64'h00FF_A5C3_5A00_0000;
    xfer(1'b1, fifo_sync_pkg::OFF_MODE_CTRL, 32'h7);
    settle();
    chk("rx entry clear", 32'h1, {31'h0, buffer_vacant});
    base = edge_cnt;
    run <= 1'b1;
    for (int n = 0; n < 400 && edge_cnt - base < 16'd40; n++) @(posedge pclk);
    run <= 1'b0;
    chk("rx bit count", 32'd40, {16'h0, edge_cnt - base});
    repeat (10) @(posedge pclk);
    chk("hit", 32'h1, {31'h0, pattern_hit});
    xfer(1'b1, fifo_sync_pkg::OFF_MODE_CTRL, 32'h5);
    settle();
    chk("hit cleared", 32'h0, {31'h0, pattern_hit});
    rchk(fifo_sync_pkg::OFF_FIFO_DATA, 32'h5A);
    xfer(1'b1, fifo_sync_pkg::OFF_FIFO_DATA, 32'h3C);
    xfer(1'b1, fifo_sync_pkg::OFF_FIFO_DATA, 32'h81);
    xfer(1'b1, fifo_sync_pkg::OFF_MODE_CTRL, 32'h6);
    run <= 1'b1;
    wait_for(1'b1, 800);
    chk("tx drained", 32'h1, {31'h0, buffer_vacant});
    xfer(1'b1, fifo_sync_pkg::OFF_MODE_CTRL, 32'h5);
    wait_for(1'b0, 200);
    run <= 1'b0;
    found = 1'b0;
    for (int k = 0; k <= 32; k++) if (tx_cap[k +: 32] === 32'hA5C3_3C81) found = 1'b1;
    chk("tx stream", 32'h1, {31'h0, found});
    conclude();
  end
endmodule
`default_nettype wire
